// >>> split_timer_pkg.sv
// constants, register map and clock-source encoding for the split 8-bit reload timer
// assumes a single 40 MHz clock and a simple strobe register port
package split_timer_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLKCTL = 4'h1;
  localparam logic [3:0] ADDR_LOW_RELOAD = 4'h2;
  localparam logic [3:0] ADDR_HIGH_RELOAD = 4'h3;
  localparam logic [3:0] ADDR_LOW_COUNT = 4'h4;
  localparam logic [3:0] ADDR_HIGH_COUNT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h8;
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h9;
  // control register fields
  localparam int CTL_HIGH_FLAG = 7;
  localparam int CTL_LOW_FLAG = 6;
  localparam int CTL_LOW_IRQ_EN = 5;
  localparam int CTL_SPLIT = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CAPTURE = 1;
  localparam int CTL_EXT_SEL = 0;
  // clock control register fields
  localparam int CLK_HIGH_MODE = 1;
  localparam int CLK_LOW_MODE = 0;
  localparam int CLK_TIMER_IRQ_EN = 2;
  // interrupt status/mask bits
  localparam int ST_HIGH_OVF = 0;
  localparam int ST_LOW_OVF = 1;
  localparam int ST_CAPTURE = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [3:0] SYS_DIV = 4'hB; // divide by 12: count 0..11
  localparam logic [2:0] EXT_DIV = 3'h7; // divide by 8: count 0..7
  localparam int CAP_DEPTH = 2;
  typedef enum logic [1:0] {SRC_SYS, SRC_DIV12, SRC_EXT8} clk_src_t;
endpackage

// >>> split_timer_capture_mem.sv
`timescale 1ns/1ps
// two-entry capture store: entry 0 low half, entry 1 high half
// assumes writes and reads on the same clock; read data are registered
module split_timer_capture_mem (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic rd_sel,
  output logic [7:0] rd_data
);
  logic [7:0] mem [split_timer_pkg::CAP_DEPTH];
  logic [7:0] next_mem [split_timer_pkg::CAP_DEPTH];
  logic [7:0] next_rd_data;

  // compute stored bytes and read output
  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[0] = wr_data[7:0];
      next_mem[1] = wr_data[15:8];
    end
    next_rd_data = mem[rd_sel];
  end

  // register stored bytes and read output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem[0] <= split_timer_pkg::RESET_BYTE;
      mem[1] <= split_timer_pkg::RESET_BYTE;
      rd_data <= split_timer_pkg::RESET_BYTE;
    end else begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end
endmodule

// >>> split_timer.sv
`timescale 1ns/1ps
// split-mode timer: two 8-bit auto-reload counters with flags, capture and interrupt
// assumes inputs synchronous to mclk and a register master that never waits
module split_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_clk_tick,
  input wire logic comparator_out,
  output logic irq,
  output logic timer_irq
);
  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] timer_control_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] low_reload_value;
  logic [7:0] high_reload_value;
  logic [7:0] low_count;
  logic [7:0] high_count;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [3:0] div12_cnt;
  logic [2:0] ext_cnt;
  logic ext_prev;
  logic comp_prev;
  logic rd_is_cap;
  logic [7:0] next_timer_control_reg;
  logic [7:0] next_clock_control_reg;
  logic [7:0] next_low_reload_value;
  logic [7:0] next_high_reload_value;
  logic [7:0] next_low_count;
  logic [7:0] next_high_count;
  logic [2:0] next_irq_status;
  logic [2:0] next_irq_mask;
  logic [3:0] next_div12_cnt;
  logic [2:0] next_ext_cnt;
  logic [7:0] next_reg_rdata;
  logic next_irq;
  logic next_timer_irq;
  logic next_rd_is_cap;
  logic [7:0] cap_rdata;

  // split setting and field decoding
  logic split_mode_sel;
  logic high_run_ctl;
  logic ext_clk_sel;
  logic high_clk_mode;
  logic low_clk_mode;
  logic low_flag_irq_en;
  logic capture_en;
  logic timer_irq_en;
  logic tick_sys12;
  logic tick_ext8;
  logic high_tick;
  logic low_tick;
  logic high_wrap;
  logic low_wrap;
  logic cap_event;
  logic wr_hit_ctrl;

  assign split_mode_sel = timer_control_reg[split_timer_pkg::CTL_SPLIT];
  assign high_run_ctl = timer_control_reg[split_timer_pkg::CTL_RUN];
  assign ext_clk_sel = timer_control_reg[split_timer_pkg::CTL_EXT_SEL];
  assign capture_en = timer_control_reg[split_timer_pkg::CTL_CAPTURE];
  assign low_flag_irq_en = timer_control_reg[split_timer_pkg::CTL_LOW_IRQ_EN];
  assign high_clk_mode = clock_control_reg[split_timer_pkg::CLK_HIGH_MODE];
  assign low_clk_mode = clock_control_reg[split_timer_pkg::CLK_LOW_MODE];
  assign timer_irq_en = clock_control_reg[split_timer_pkg::CLK_TIMER_IRQ_EN];

  // pick the clock source from a mode bit and the shared external select
  function automatic split_timer_pkg::clk_src_t pick_src(input logic mode, input logic ext);
    if (mode) begin
      pick_src = split_timer_pkg::SRC_SYS;
    end else if (ext) begin
      pick_src = split_timer_pkg::SRC_EXT8;
    end else begin
      pick_src = split_timer_pkg::SRC_DIV12;
    end
  endfunction

  // turn a source choice into a count enable
  function automatic logic src_tick(input split_timer_pkg::clk_src_t src, input logic t12, input logic t8);
    case (src)
      split_timer_pkg::SRC_SYS: src_tick = 1'b1;
      split_timer_pkg::SRC_DIV12: src_tick = t12;
      split_timer_pkg::SRC_EXT8: src_tick = t8;
      default: src_tick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // prescalers: system_clock/12 and external edge /8
  assign tick_sys12 = (div12_cnt == split_timer_pkg::SYS_DIV);
  assign tick_ext8 = ext_clk_tick && !ext_prev && (ext_cnt == split_timer_pkg::EXT_DIV);

  always_comb begin
    next_div12_cnt = tick_sys12 ? 4'h0 : div12_cnt + 4'h1;
    next_ext_cnt = ext_cnt;
    if (ext_clk_tick && !ext_prev) begin
      next_ext_cnt = ext_cnt + 3'h1; // wraps after eight rising edges
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div12_cnt <= 4'h0;
      ext_cnt <= 3'h0;
      ext_prev <= 1'b0;
      comp_prev <= 1'b0;
    end else begin
      div12_cnt <= next_div12_cnt;
      ext_cnt <= next_ext_cnt;
      ext_prev <= ext_clk_tick;
      comp_prev <= comparator_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters
  assign high_tick = src_tick(pick_src(high_clk_mode, ext_clk_sel), tick_sys12, tick_ext8);
  assign low_tick = src_tick(pick_src(low_clk_mode, ext_clk_sel), tick_sys12, tick_ext8);
  // low half free-runs in split mode; high half only with run control
  assign high_wrap = split_mode_sel && high_run_ctl && high_tick
    && (high_count == split_timer_pkg::COUNT_MAX);
  assign low_wrap = split_mode_sel && low_tick && (low_count == split_timer_pkg::COUNT_MAX);
  assign cap_event = capture_en && comparator_out && !comp_prev;
  assign wr_hit_ctrl = reg_wr && (reg_addr == split_timer_pkg::ADDR_CTRL);

  // counter next values; software writes to a count register win over counting
  always_comb begin
    next_high_count = high_count;
    next_low_count = low_count;
    if (split_mode_sel) begin
      if (high_wrap) begin
        next_high_count = high_reload_value;
      end else if (high_run_ctl && high_tick) begin
        next_high_count = high_count + 8'h01;
      end
      if (low_wrap) begin
        next_low_count = low_reload_value;
      end else if (low_tick) begin
        next_low_count = low_count + 8'h01;
      end
    end
    if (reg_wr && reg_addr == split_timer_pkg::ADDR_HIGH_COUNT) begin
      next_high_count = reg_wdata;
    end
    if (reg_wr && reg_addr == split_timer_pkg::ADDR_LOW_COUNT) begin
      next_low_count = reg_wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_count <= split_timer_pkg::RESET_BYTE;
      low_count <= split_timer_pkg::RESET_BYTE;
    end else begin
      high_count <= next_high_count;
      low_count <= next_low_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers and overflow flags
  always_comb begin
    next_timer_control_reg = timer_control_reg;
    next_clock_control_reg = clock_control_reg;
    next_low_reload_value = low_reload_value;
    next_high_reload_value = high_reload_value;
    next_irq_mask = irq_mask;
    if (wr_hit_ctrl) begin
      next_timer_control_reg = reg_wdata; // flags cleared only by software writes
    end
    if (reg_wr && reg_addr == split_timer_pkg::ADDR_CLKCTL) begin
      next_clock_control_reg = reg_wdata;
    end
    if (reg_wr && reg_addr == split_timer_pkg::ADDR_LOW_RELOAD) begin
      next_low_reload_value = reg_wdata;
    end
    if (reg_wr && reg_addr == split_timer_pkg::ADDR_HIGH_RELOAD) begin
      next_high_reload_value = reg_wdata;
    end
    if (reg_wr && reg_addr == split_timer_pkg::ADDR_IRQ_MASK) begin
      next_irq_mask = reg_wdata[2:0];
    end
    // set wins over a simultaneous software write
    if (high_wrap) begin
      next_timer_control_reg[split_timer_pkg::CTL_HIGH_FLAG] = 1'b1;
    end
    if (low_wrap) begin
      next_timer_control_reg[split_timer_pkg::CTL_LOW_FLAG] = 1'b1;
    end
    next_timer_control_reg[4] = 1'b0; // unused bit reads zero
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_control_reg <= split_timer_pkg::RESET_BYTE;
      clock_control_reg <= split_timer_pkg::RESET_BYTE;
      low_reload_value <= split_timer_pkg::RESET_BYTE;
      high_reload_value <= split_timer_pkg::RESET_BYTE;
      irq_mask <= 3'h0;
    end else begin
      timer_control_reg <= next_timer_control_reg;
      clock_control_reg <= next_clock_control_reg;
      low_reload_value <= next_low_reload_value;
      high_reload_value <= next_high_reload_value;
      irq_mask <= next_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, clear on read, and interrupt outputs
  always_comb begin
    next_irq_status = irq_status;
    if (reg_rd && reg_addr == split_timer_pkg::ADDR_IRQ_STATUS) begin
      next_irq_status = 3'h0;
    end
    if (high_wrap) begin
      next_irq_status[split_timer_pkg::ST_HIGH_OVF] = 1'b1;
    end
    if (low_wrap) begin
      next_irq_status[split_timer_pkg::ST_LOW_OVF] = 1'b1;
    end
    if (cap_event) begin
      next_irq_status[split_timer_pkg::ST_CAPTURE] = 1'b1;
    end
    next_irq = |(next_irq_status & irq_mask);
    // with timer_irq_en set, timer interrupt follows the flags: high always, low only when enabled
    next_timer_irq = timer_irq_en && (next_timer_control_reg[split_timer_pkg::CTL_HIGH_FLAG]
      || (next_timer_control_reg[split_timer_pkg::CTL_LOW_IRQ_EN]
      && next_timer_control_reg[split_timer_pkg::CTL_LOW_FLAG]));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= next_irq;
      timer_irq <= next_timer_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture store
  split_timer_capture_mem u_cap (
    .mclk(mclk),
    .rst(rst),
    .wr_en(cap_event),
    .wr_data({high_count, low_count}),
    .rd_sel(reg_addr == split_timer_pkg::ADDR_CAPTURE_HIGH),
    .rd_data(cap_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero otherwise
  always_comb begin
    next_reg_rdata = 8'h00;
    next_rd_is_cap = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        split_timer_pkg::ADDR_CTRL: next_reg_rdata = timer_control_reg;
        split_timer_pkg::ADDR_CLKCTL: next_reg_rdata = clock_control_reg;
        split_timer_pkg::ADDR_LOW_RELOAD: next_reg_rdata = low_reload_value;
        split_timer_pkg::ADDR_HIGH_RELOAD: next_reg_rdata = high_reload_value;
        split_timer_pkg::ADDR_LOW_COUNT: next_reg_rdata = low_count;
        split_timer_pkg::ADDR_HIGH_COUNT: next_reg_rdata = high_count;
        split_timer_pkg::ADDR_IRQ_STATUS: next_reg_rdata = {5'h00, irq_status};
        split_timer_pkg::ADDR_IRQ_MASK: next_reg_rdata = {5'h00, irq_mask};
        split_timer_pkg::ADDR_CAPTURE_LOW: next_rd_is_cap = 1'b1;
        split_timer_pkg::ADDR_CAPTURE_HIGH: next_rd_is_cap = 1'b1;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_is_cap <= 1'b0;
    end else begin
      rd_is_cap <= next_rd_is_cap;
    end
  end

  // capture bytes come from the memory register, others from this stage
  logic [7:0] rdata_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= next_reg_rdata;
    end
  end
  assign reg_rdata = rd_is_cap ? cap_rdata : rdata_reg;
endmodule

// >>> split_timer_assertions.sv
`timescale 1ns/1ps
// checker for the split 8-bit reload timer: register echo, interrupt gating
// sees only the top ports and rebuilds the written registers from the strobes
module split_timer_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_clk_tick,
  input wire logic comparator_out,
  input wire logic irq,
  input wire logic timer_irq
);
  logic [7:0] sh [0:7];
  logic [7:0] next_sh [0:7];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of every writable address below 8
  always_comb begin
    next_sh = sh;
    if (reg_wr && !reg_addr[3]) next_sh[reg_addr[2:0]] = reg_wdata;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sh <= '{default: 8'h00};
    else sh <= next_sh;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // read answers and interrupt outputs
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_ctrl_echo: assert property (reg_rd && reg_addr == split_timer_pkg::ADDR_CTRL
    |=> reg_rdata[5:0] == {sh[0][5], 1'b0, sh[0][3:0]}) else $error("control bits read back wrong");
  chk_clk_echo: assert property (reg_rd && reg_addr == split_timer_pkg::ADDR_CLKCTL
    |=> reg_rdata[2:0] == sh[1][2:0]) else $error("clock control read back wrong");
  chk_low_reload: assert property (reg_rd && reg_addr == split_timer_pkg::ADDR_LOW_RELOAD
    |=> reg_rdata == sh[2]) else $error("low reload read back wrong");
  chk_high_reload: assert property (reg_rd && reg_addr == split_timer_pkg::ADDR_HIGH_RELOAD
    |=> reg_rdata == sh[3]) else $error("high reload read back wrong");
  chk_tirq_gated: assert property (!sh[1][2] && !$past(sh[1][2]) |-> !timer_irq)
    else $error("timer interrupt while disabled");
  chk_irq_masked: assert property (sh[7][2:0] == 3'h0 && $past(sh[7][2:0]) == 3'h0 |-> !irq)
    else $error("interrupt with all mask bits clear");
  // a control write in the first cycle drops timer_irq at once, so that cycle must be write-free; the check also keeps the next cycle write-free
  chk_tirq_hold: assert property (timer_irq && !reg_wr ##1 !reg_wr |-> timer_irq)
    else $error("timer interrupt dropped without a write");
  chk_low_moves: assert property (reg_rd && reg_addr == split_timer_pkg::ADDR_LOW_COUNT && sh[0][3] && sh[1][0]
    && sh[2] != 8'hFF ##1 reg_rd && reg_addr == split_timer_pkg::ADDR_LOW_COUNT |=> reg_rdata != $past(reg_rdata))
    else $error("fast low counter stood still");
  cov_two_reads: cover property (reg_rd ##1 reg_rd);
  cov_tirq: cover property ($rose(timer_irq));
  cov_irq: cover property ($rose(irq));
endmodule

// >>> split_timer_bench.sv
`timescale 1ns/1ps
// self-checking bench for the split 8-bit reload timer
// drives the register port, external tick and comparator by itself
module split_timer_bench;
  logic mclk, rst, reg_wr, reg_rd, ext_clk_tick, comparator_out, irq, timer_irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, w, r;
  logic [7:0] m [0:7];
  int fail_count, compares, seed;
  split_timer i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_tick(ext_clk_tick), .comparator_out(comparator_out),
    .irq(irq), .timer_irq(timer_irq));
  // 25 ns clock
  always #12.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one-cycle write strobe; the model keeps what software wrote
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (!a[3]) m[a[2:0]] = d;
  endtask
  // one-cycle read strobe; data stand in the following cycle only
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check($sformatf("reg %0h", a), d, exp);
  endtask
  // two low-count reads back to back
  task automatic rd2(output logic [7:0] d0, output logic [7:0] d1);
    @(posedge mclk);
    reg_addr <= split_timer_pkg::ADDR_LOW_COUNT;
    reg_rd <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    d0 = reg_rdata;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d1 = reg_rdata;
  endtask
  task automatic wait_tirq(input int n);
    for (int i = 0; i < n && timer_irq !== 1'b1; i++) @(negedge mclk);
    check("timer_irq", {7'h00, timer_irq}, 8'h01);
    if (timer_irq !== 1'b1) finish_test();
  endtask
  task automatic pulse();
    @(posedge mclk);
    comparator_out <= 1'b1;
    repeat (3) @(posedge mclk);
    comparator_out <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // count one half from zero and compare with the expected tick total
  task automatic rate(input int h, input int s);
    int e, t;
    wr(split_timer_pkg::ADDR_CLKCTL, s == 0 ? 8'(1 << h) : 8'h00);
    wr(split_timer_pkg::ADDR_CTRL, s == 2 ? 8'h0D : 8'h0C);
    wr(4'(4 + h), 8'h00);
    e = s == 0 ? 42 : (s == 1 ? 50 : 3);
    t = s == 1 ? 2 : (s == 0 ? 2 : 1);
    if (s == 2) begin
      repeat (24) begin
        @(posedge mclk);
        ext_clk_tick <= 1'b1;
        repeat (1 + $urandom_range(2)) @(posedge mclk);
        ext_clk_tick <= 1'b0;
        repeat (1 + $urandom_range(2)) @(posedge mclk);
      end
    end else begin
      repeat (s == 0 ? 40 : 600) @(posedge mclk);
    end
    rd(4'(4 + h), v);
    check("rate", 8'(int'(v) >= e - t && int'(v) <= e + t), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk, reg_wr, reg_rd, ext_clk_tick, comparator_out} = 5'h00;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    m = '{default: 8'h00};
    fail_count = 0;
    compares = 0;
    seed = $urandom(75741);
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    // every address after reset, unmapped ones included
    for (int a = 0; a < 16; a++) rchk(4'(a), 8'h00);
    // counters hold outside split mode
    r = 8'($urandom_range(254));
    wr(split_timer_pkg::ADDR_LOW_RELOAD, r);
    wr(split_timer_pkg::ADDR_HIGH_RELOAD, 8'($urandom));
    wr(split_timer_pkg::ADDR_CLKCTL, 8'h03);
    wr(split_timer_pkg::ADDR_LOW_COUNT, 8'hFE);
    // run control alone must neither count nor flag without split mode
    wr(split_timer_pkg::ADDR_HIGH_COUNT, 8'hFF);
    wr(split_timer_pkg::ADDR_CTRL, 8'h04);
    repeat (20) @(posedge mclk);
    rchk(split_timer_pkg::ADDR_LOW_COUNT, 8'hFE);
    rchk(split_timer_pkg::ADDR_HIGH_COUNT, 8'hFF);
    rchk(split_timer_pkg::ADDR_CTRL, 8'h04);
    rchk(split_timer_pkg::ADDR_HIGH_RELOAD, m[3]);
    // split: low runs free and reloads, high waits for run control
    wr(split_timer_pkg::ADDR_HIGH_COUNT, 8'h40);
    wr(split_timer_pkg::ADDR_CTRL, 8'h08);
    rd2(v, w);
    check("low_step", 8'(w == v + 8'h01 || (v == 8'hFF && w == r)), 8'h01);
    repeat (10) @(posedge mclk);
    rchk(split_timer_pkg::ADDR_CTRL, 8'h48);
    rchk(split_timer_pkg::ADDR_HIGH_COUNT, 8'h40);
    rd(split_timer_pkg::ADDR_LOW_COUNT, v);
    check("low_range", 8'(v >= r), 8'h01);
    // timer interrupt from each half
    wr(split_timer_pkg::ADDR_CLKCTL, 8'h07);
    repeat (3) @(negedge mclk);
    check("timer_irq", {7'h00, timer_irq}, 8'h00);
    wr(split_timer_pkg::ADDR_CTRL, 8'h28);
    wait_tirq(600);
    wr(split_timer_pkg::ADDR_CTRL, 8'h08);
    repeat (3) @(negedge mclk);
    check("timer_irq", {7'h00, timer_irq}, 8'h00);
    wr(split_timer_pkg::ADDR_CTRL, 8'h0C);
    wait_tirq(600);
    rd(split_timer_pkg::ADDR_CTRL, v);
    check("high_flag", {7'h00, v[7]}, 8'h01);
    // freeze both halves; flags stay until software clears them
    // both flags written as one, so a wrap landing on the write cannot change the expectation
    wr(split_timer_pkg::ADDR_CLKCTL, 8'h04);
    wr(split_timer_pkg::ADDR_CTRL, 8'hC9);
    repeat (50) @(posedge mclk);
    rchk(split_timer_pkg::ADDR_CTRL, 8'hC9);
    check("timer_irq", {7'h00, timer_irq}, 8'h01);
    wr(split_timer_pkg::ADDR_CTRL, 8'h09);
    rchk(split_timer_pkg::ADDR_CTRL, 8'h09);
    // capture, status read-clear and mask; both halves have wrapped since the reset scan
    rchk(split_timer_pkg::ADDR_IRQ_STATUS, 8'h03);
    wr(split_timer_pkg::ADDR_IRQ_MASK, 8'h04);
    wr(split_timer_pkg::ADDR_LOW_COUNT, 8'($urandom));
    wr(split_timer_pkg::ADDR_HIGH_COUNT, 8'($urandom));
    wr(split_timer_pkg::ADDR_CTRL, 8'h0B);
    pulse();
    rchk(split_timer_pkg::ADDR_CAPTURE_LOW, m[4]);
    rchk(split_timer_pkg::ADDR_CAPTURE_HIGH, m[5]);
    check("irq", {7'h00, irq}, 8'h01);
    rchk(split_timer_pkg::ADDR_IRQ_STATUS, 8'h04);
    repeat (2) @(negedge mclk);
    check("irq", {7'h00, irq}, 8'h00);
    rchk(split_timer_pkg::ADDR_IRQ_STATUS, 8'h00);
    wr(split_timer_pkg::ADDR_IRQ_MASK, 8'h00);
    pulse();
    check("irq", {7'h00, irq}, 8'h00);
    rchk(split_timer_pkg::ADDR_IRQ_STATUS, 8'h04);
    // every clock source for each half
    for (int h = 0; h < 2; h++) for (int s = 0; s < 3; s++) rate(h, s);
    finish_test();
  end
endmodule
bind split_timer split_timer_checker i_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_tick(ext_clk_tick),
  .comparator_out(comparator_out), .irq(irq), .timer_irq(timer_irq));
